/* hold_timer.sv */
// Hold timer: fires one pulse when a level stays high longer than a time.
// Assumes its input is already synchronised to i_clock.
`timescale 1ns/1ns
module hold_timer
    import tgt_pkg::*;
#(
    parameter int HOLD_CYC = 100
) (
    input wire logic i_clock, // System clock.
    input wire logic i_rst_n, // Synchronous reset, active low.
    input wire logic i_level, // Gesture level.
    output logic o_fire // One-cycle pulse after the hold.
);
    logic [31:0] count;
    logic done;
    wire at_limit = (count == 32'(HOLD_CYC));

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !i_level) begin
            count <= 32'h00000000;
            done <= 1'b0;
            o_fire <= 1'b0;
        end else begin
            if (!at_limit) begin
                count <= count + 32'h00000001;
            end
            o_fire <= at_limit && !done;
            done <= done | at_limit;
        end
    end

    a_fire_once: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_fire |=> !o_fire) else $error("hold timer fired twice");
endmodule

/* operator_panel.sv */
// Model of the operator push buttons and the remote reset contact.
// Assumes the bench calls its tasks; levels change just after rising edges.
`timescale 1ns/1ns
module operator_panel (
    input wire logic i_clock, // System clock.
    output logic o_button_a, // First button, high = pressed.
    output logic o_button_b, // Second button, high = pressed.
    output logic o_remote_closed // Remote contact, high = closed.
);
    initial begin
        o_button_a = 1'b0;
        o_button_b = 1'b0;
        o_remote_closed = 1'b0;
    end
    // Presses both buttons together for n cycles, then lets go of both.
    task automatic hold_buttons(input int n);
        @(posedge i_clock);
        o_button_a <= 1'b1;
        o_button_b <= 1'b1;
        repeat (n) @(posedge i_clock);
        o_button_a <= 1'b0;
        o_button_b <= 1'b0;
    endtask
    // Connects the two remote terminals for n cycles.
    task automatic close_remote(input int n);
        @(posedge i_clock);
        o_remote_closed <= 1'b1;
        repeat (n) @(posedge i_clock);
        o_remote_closed <= 1'b0;
    endtask
endmodule

/* test_total_grand_total_counter.sv */
// Self-checking bench of the total and grand total counter.
// Assumes short hold parameters; registers are reached over APB.
`timescale 1ns/1ns
module test_total_grand_total_counter
    import tgt_pkg::*;
;
    logic i_clock;
    logic i_rst_n;
    logic i_count;
    logic i_psel;
    logic i_penable;
    logic i_pwrite;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata;
    logic [3:0] i_pstrb;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_irq, o_overflow;
    logic o_cleared_show, o_dashes, o_locked;
    logic button_a, button_b, remote_closed;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int checked = 0;
    longint exp_total = 0;
    longint exp_grand = 0;

    always #5 i_clock = ~i_clock;

    total_grand_total_counter #(.TOTAL_HOLD(20), .GRAND_HOLD(40),
        .REMOTE_HOLD(10), .SHOW_HOLD(8)) dut_u (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_count(i_count), .i_button_a(button_a),
        .i_button_b(button_b), .i_remote_closed(remote_closed),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_irq(o_irq), .o_overflow(o_overflow),
        .o_cleared_show(o_cleared_show), .o_dashes(o_dashes),
        .o_locked(o_locked));

    operator_panel panel_u (.i_clock(i_clock), .o_button_a(button_a),
        .o_button_b(button_b), .o_remote_closed(remote_closed));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (o_pready !== 1'b1 && k < 20);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (o_pready !== 1'b1) begin
            check("pready", 32'h1, 32'h0);
            close_out();
        end
    endtask

    task automatic rdc(input string n, input logic [7:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        check(n, e, rd);
    endtask

    task automatic pulses(input int n, input bit up);
        int s;
        s = up ? 1 : -1;
        repeat (n) begin
            @(posedge i_clock);
            i_count <= 1'b1;
        end
        @(posedge i_clock);
        i_count <= 1'b0;
        exp_total += n * s;
        exp_grand += n * s;
    endtask

    task automatic totals();
        repeat (4) @(posedge i_clock);
        rdc("total", OFF_TOTAL, 32'(exp_total));
        rdc("grand low", OFF_GRAND_LO, 32'(exp_grand % 100000000));
        rdc("grand high", OFF_GRAND_HI, 32'(exp_grand / 100000000));
    endtask

    task automatic await(ref logic f, input logic v, input string n);
        int k;
        k = 0;
        while (f !== v && k < 30) begin
            @(posedge i_clock);
            k++;
        end
        check(n, {31'h0, v}, {31'h0, f});
        if (f !== v) close_out();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdc("ctrl", OFF_CTRL, 32'h00000000);
        rdc("reload", OFF_RELOAD, RELOAD_RESET);
        rdc("active code", OFF_ACTIVE_CODE, 32'h00000000);
        rdc("mask", OFF_MASK, 32'h00000000);
        apb(1'b0, 8'h28, 32'h00000000);
        check("slave error", 32'h1, {31'h0, err});
        check("irq", 32'h0, {31'h0, o_irq});
        $display("test reset done");
    endtask

    task automatic t_count();
        pulses(5, 1'b1);
        totals();
        apb(1'b1, OFF_RELOAD, 32'h00000003);
        apb(1'b1, OFF_CTRL, 32'h00000001);
        panel_u.close_remote(8);
        panel_u.close_remote(8);
        totals();
        panel_u.close_remote(16);
        exp_total = 3;
        totals();
        pulses(2, 1'b0);
        totals();
        $display("test count done");
    endtask

    task automatic t_panel();
        apb(1'b1, OFF_CTRL, 32'h00000000);
        apb(1'b1, OFF_RELOAD, 32'h00000000);
        pulses(2, 1'b1);
        panel_u.hold_buttons(30);
        totals();
        apb(1'b1, OFF_CTRL, 32'h00000002);
        apb(1'b1, OFF_STATUS, 32'h0000000F);
        apb(1'b1, OFF_MASK, 32'h00000001);
        panel_u.hold_buttons(8);
        totals();
        fork
            panel_u.hold_buttons(60);
            begin
                repeat (5) @(posedge i_clock);
                pulses(1, 1'b1);
            end
        join
        exp_total = 0;
        totals();
        check("irq set", 32'h1, {31'h0, o_irq});
        apb(1'b1, OFF_MASK, 32'h00000000);
        @(posedge i_clock);
        check("irq masked", 32'h0, {31'h0, o_irq});
        apb(1'b1, OFF_MASK, 32'h00000001);
        @(posedge i_clock);
        check("irq unmasked", 32'h1, {31'h0, o_irq});
        apb(1'b1, OFF_STATUS, 32'h00000001);
        @(posedge i_clock);
        check("irq cleared", 32'h0, {31'h0, o_irq});
        $display("test panel done");
    endtask

    task automatic t_grand();
        apb(1'b1, OFF_CTRL, 32'h00000004);
        panel_u.hold_buttons(55);
        exp_grand = 0;
        totals();
        pulses(2, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h00000010);
        apb(1'b1, OFF_CMD, 32'h12340001);
        totals();
        i_pstrb <= 4'h1;
        apb(1'b1, OFF_CMD, {CONFIRM_WORD, 16'h0001});
        i_pstrb <= 4'hF;
        totals();
        apb(1'b1, OFF_CMD, {CONFIRM_WORD, 16'h0001});
        exp_grand = 0;
        await(o_cleared_show, 1'b1, "cleared shown");
        totals();
        await(o_cleared_show, 1'b0, "cleared ends");
        $display("test grand done");
    endtask

    task automatic t_code();
        apb(1'b1, OFF_CODE, 32'h00001234);
        rdc("code held", OFF_ACTIVE_CODE, 32'h00000000);
        apb(1'b1, OFF_CTRL, 32'h00000000);
        rdc("code applied", OFF_ACTIVE_CODE, 32'h00001234);
        await(o_locked, 1'b1, "locked");
        apb(1'b1, OFF_RELOAD, 32'h00000007);
        rdc("locked reload", OFF_RELOAD, 32'h00000000);
        apb(1'b1, OFF_CTRL, 32'h12340010);
        apb(1'b1, OFF_CMD, {CONFIRM_WORD, 16'h0002});
        await(o_dashes, 1'b1, "dashes");
        await(o_dashes, 1'b0, "dashes end");
        exp_total = 0;
        exp_grand = 0;
        totals();
        rdc("ctrl default", OFF_CTRL, 32'h00000000);
        rdc("reload default", OFF_RELOAD, RELOAD_RESET);
        rdc("code default", OFF_ACTIVE_CODE, 32'h00000000);
        check("unlocked", 32'h0, {31'h0, o_locked});
        $display("test code done");
    endtask

    task automatic t_over();
        apb(1'b1, OFF_RELOAD, 32'h05F5E0FF);
        panel_u.close_remote(16);
        exp_total = 99999999;
        await(o_overflow, 1'b0, "in range");
        pulses(1, 1'b1);
        await(o_overflow, 1'b1, "over upper");
        totals();
        apb(1'b1, OFF_CTRL, 32'h00000001);
        pulses(1, 1'b0);
        await(o_overflow, 1'b0, "back in upper");
        apb(1'b1, OFF_CTRL, 32'h00000008);
        await(o_overflow, 1'b1, "over lower");
        apb(1'b1, OFF_RELOAD, 32'h000F423F);
        panel_u.close_remote(16);
        exp_total = 999999;
        await(o_overflow, 1'b0, "in lower");
        pulses(1, 1'b1);
        await(o_overflow, 1'b1, "past lower");
        totals();
        $display("test overflow done");
    endtask

    initial begin
        i_clock = 1'b0;
        i_rst_n = 1'b0;
        i_count = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h00000000;
        i_pstrb = 4'hF;
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_reset();
        t_count();
        t_panel();
        t_grand();
        t_code();
        t_over();
        close_out();
    end
endmodule

/* tgt_pkg.sv */
// Package for the total and grand total counter block.
// Assumes one 100 MHz clock; every other file but the operator panel model imports this package whole.
package tgt_pkg;
    localparam int CLK_MHZ = 100;
    // Hold times of the operator gestures, in milliseconds.
    localparam int TOTAL_HOLD_MS = 3000;
    localparam int GRAND_HOLD_MS = 10000;
    localparam int REMOTE_HOLD_MS = 1000;
    localparam int TOTAL_HOLD_CYC = TOTAL_HOLD_MS * 1000 * CLK_MHZ;
    localparam int GRAND_HOLD_CYC = GRAND_HOLD_MS * 1000 * CLK_MHZ;
    localparam int REMOTE_HOLD_CYC = REMOTE_HOLD_MS * 1000 * CLK_MHZ;
    // Length of the cleared indication and of the restore dashes.
    localparam int SHOW_MS = 1000;
    localparam int SHOW_CYC = SHOW_MS * 1000 * CLK_MHZ;
    // Display ranges of the total.
    localparam logic signed [63:0] UPPER_MAX = 64'sd99999999;
    localparam logic signed [63:0] UPPER_MIN = -64'sd9999999;
    localparam logic signed [63:0] LOWER_MAX = 64'sd999999;
    localparam logic signed [63:0] LOWER_MIN = -64'sd99999;
    // Grand total limit: sixteen decimal digits.
    localparam logic signed [63:0] GRAND_MAX = 64'sd9999999999999999;
    localparam logic [31:0] HALF_DIV = 32'd100000000;
    // APB register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RELOAD = 8'h04;
    localparam logic [7:0] OFF_CODE = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    localparam logic [7:0] OFF_TOTAL = 8'h18;
    localparam logic [7:0] OFF_GRAND_LO = 8'h1C;
    localparam logic [7:0] OFF_GRAND_HI = 8'h20;
    localparam logic [7:0] OFF_ACTIVE_CODE = 8'h24;
    // Control register fields and reset values.
    localparam int CTRL_DOWN = 0;
    localparam int CTRL_TOTAL_EN = 1;
    localparam int CTRL_GRAND_EN = 2;
    localparam int CTRL_LOWER = 3;
    localparam int CTRL_CFG = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [31:0] RELOAD_RESET = 32'h00000000;
    // Command register fields: the confirmation word sits in 31:16.
    localparam int CMD_GRAND_CLR = 0;
    localparam int CMD_RESTORE = 1;
    localparam logic [15:0] CONFIRM_WORD = 16'h5A5E;
    // Status bits.
    localparam int ST_TOTAL_RL = 0;
    localparam int ST_GRAND_CLR = 1;
    localparam int ST_OVERFLOW = 2;
    localparam int ST_RESTORED = 3;
    localparam int ST_W = 4;
endpackage

/* total_grand_total_counter.sv */
// Total and grand total counter with reload, gesture resets and menu
// commands. Assumes count pulses from same-clock logic and raw pins for
// the buttons and the remote contact; registers reached over APB.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
module total_grand_total_counter
    import tgt_pkg::*;
#(
    parameter int TOTAL_HOLD = TOTAL_HOLD_CYC,
    parameter int GRAND_HOLD = GRAND_HOLD_CYC,
    parameter int REMOTE_HOLD = REMOTE_HOLD_CYC,
    parameter int SHOW_HOLD = SHOW_CYC
) (
    input wire logic i_clock, // System clock, 100 MHz.
    input wire logic i_rst_n, // Synchronous reset, active low.
    input wire logic i_count, // One-cycle counted pulse.
    input wire logic i_button_a, // First designated button, raw pin.
    input wire logic i_button_b, // Second designated button, raw pin.
    input wire logic i_remote_closed, // Remote contact closed, raw pin.
    input wire logic i_psel, // APB select.
    input wire logic i_penable, // APB enable.
    input wire logic i_pwrite, // APB write.
    input wire logic [7:0] i_paddr, // APB byte address.
    input wire logic [31:0] i_pwdata, // APB write data.
    input wire logic [3:0] i_pstrb, // APB byte strobes.
    output logic [31:0] o_prdata, // APB read data.
    output logic o_pready, // APB ready.
    output logic o_pslverr, // APB error.
    output logic o_irq, // Level interrupt.
    output logic o_overflow, // Display saturated, points flash.
    output logic o_cleared_show, // Cleared indication shown.
    output logic o_dashes, // Restore dashes shown.
    output logic o_locked // Configuration gated by code.
);
    // ************************************************************
    // State and registers
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_DISPLAY = 3'b001,
        MODE_CONFIG = 3'b010,
        MODE_RESTORE = 3'b100
    } mode_t;

    mode_t mode;
    mode_t next_mode;
    logic [4:0] ctrl;
    logic [31:0] reload_value;
    logic [15:0] access_code;
    logic [15:0] active_code;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic signed [63:0] total;
    logic signed [63:0] grand;
    logic [31:0] show_count;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] sync_r;
    logic fire_total;
    logic fire_grand;
    logic fire_remote;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
            sync_r <= 2'h0;
        end else begin
            sync_a <= {sync_a[0], i_button_a};
            sync_b <= {sync_b[0], i_button_b};
            sync_r <= {sync_r[0], i_remote_closed};
        end
    end

    wire both_held = sync_a[1] && sync_b[1];
    wire in_display = (mode == MODE_DISPLAY);
    wire total_gesture = both_held && in_display && ctrl[CTRL_TOTAL_EN];
    wire grand_gesture = both_held && in_display && ctrl[CTRL_GRAND_EN];

    // ************************************************************
    // Gesture timers
    // ************************************************************
    hold_timer #(.HOLD_CYC(TOTAL_HOLD)) u_total_hold (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_level(total_gesture),
        .o_fire(fire_total)
    );
    hold_timer #(.HOLD_CYC(GRAND_HOLD)) u_grand_hold (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_level(grand_gesture),
        .o_fire(fire_grand)
    );
    hold_timer #(.HOLD_CYC(REMOTE_HOLD)) u_remote_hold (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_level(sync_r[1]),
        .o_fire(fire_remote)
    );

    // ************************************************************
    // APB decode
    // ************************************************************
    wire wr = i_psel && i_penable && i_pwrite;
    wire rd_sel = i_psel && !i_pwrite;
    wire hit_ctrl = (i_paddr == OFF_CTRL);
    wire hit_reload = (i_paddr == OFF_RELOAD);
    wire hit_code = (i_paddr == OFF_CODE);
    wire hit_cmd = (i_paddr == OFF_CMD);
    wire hit_status = (i_paddr == OFF_STATUS);
    wire hit_mask = (i_paddr == OFF_MASK);
    wire hit_total = (i_paddr == OFF_TOTAL);
    wire hit_glo = (i_paddr == OFF_GRAND_LO);
    wire hit_ghi = (i_paddr == OFF_GRAND_HI);
    wire hit_act = (i_paddr == OFF_ACTIVE_CODE);
    wire mapped = hit_ctrl | hit_reload | hit_code | hit_cmd | hit_status
        | hit_mask | hit_total | hit_glo | hit_ghi | hit_act;
    wire locked = (active_code != CODE_RESET);
    // With a code active, only a control write carrying the code in bits 31:16 sets the CFG bit and unlocks configuration.
    wire cfg_ok = !locked || ctrl[CTRL_CFG];
    wire code_ok = (i_pwdata[31:16] == active_code);
    wire word_ok = (i_pwdata[31:16] == CONFIRM_WORD);
    wire wr_cmd = wr && hit_cmd && cfg_ok && i_pstrb == 4'hF && word_ok;
    wire do_gclr = wr_cmd && i_pwdata[CMD_GRAND_CLR];
    wire do_restore = wr_cmd && i_pwdata[CMD_RESTORE];
    wire leave_cfg = wr && hit_ctrl && i_pstrb[0] && !i_pwdata[CTRL_CFG];

    // ************************************************************
    // Counting arithmetic
    // ************************************************************
    wire down = ctrl[CTRL_DOWN];
    wire signed [63:0] reload_ext = {32'h00000000, reload_value};
    wire signed [63:0] step = down ? -64'sd1 : 64'sd1;
    wire total_reload = fire_total || fire_remote;
    wire grand_zero = fire_grand || do_gclr || do_restore;
    // The grand total wraps within sixteen decimal digits.
    wire signed [63:0] grand_step = grand + step;
    wire signed [63:0] grand_wrap = (grand_step > GRAND_MAX) ? 64'sd0 :
        (grand_step < -GRAND_MAX) ? 64'sd0 : grand_step;
    wire upper_ovf = (total > UPPER_MAX) || (total < UPPER_MIN);
    wire lower_ovf = (total > LOWER_MAX) || (total < LOWER_MIN);
    wire ovf = ctrl[CTRL_LOWER] ? lower_ovf : upper_ovf;
    wire [63:0] grand_mag = grand[63] ? 64'(-grand) : 64'(grand);
    wire [31:0] grand_lo = 32'(grand_mag % 64'(HALF_DIV));
    wire [31:0] grand_hi = 32'(grand_mag / 64'(HALF_DIV));

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || do_restore) begin
            total <= 64'sd0;
        end else if (total_reload) begin
            total <= reload_ext;
        end else if (i_count) begin
            total <= total + step;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || grand_zero) begin
            grand <= 64'sd0;
        end else if (i_count) begin
            grand <= grand_wrap;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || do_restore) begin
            ctrl <= CTRL_RESET;
            reload_value <= RELOAD_RESET;
            access_code <= CODE_RESET;
        end else if (wr && cfg_ok) begin
            if (hit_ctrl && i_pstrb[0]) begin
                ctrl <= i_pwdata[4:0];
            end
            if (hit_reload) begin
                for (int i = 0; i < 4; i++) begin
                    if (i_pstrb[i]) begin
                        reload_value[i*8 +: 8] <= i_pwdata[i*8 +: 8];
                    end
                end
            end
            if (hit_code && i_pstrb[1:0] == 2'h3) begin
                access_code <= i_pwdata[15:0];
            end
        end else if (wr && hit_ctrl && i_pstrb[0]
                && i_pwdata[31:16] == active_code) begin
            ctrl[CTRL_CFG] <= i_pwdata[CTRL_CFG];
        end
    end

    // ************************************************************
    // Mode sequencing
    // ************************************************************
    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_DISPLAY: begin
                if (do_restore) begin
                    next_mode = MODE_RESTORE;
                end else if (wr && hit_ctrl && i_pstrb[0]
                        && i_pwdata[CTRL_CFG] && (cfg_ok || code_ok)) begin
                    next_mode = MODE_CONFIG;
                end
            end
            MODE_CONFIG: begin
                if (do_restore) begin
                    next_mode = MODE_RESTORE;
                end else if (leave_cfg) begin
                    next_mode = MODE_DISPLAY;
                end
            end
            MODE_RESTORE: begin
                if (show_count == 32'(SHOW_HOLD)) begin
                    next_mode = MODE_DISPLAY;
                end
            end
            default: next_mode = MODE_DISPLAY;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            mode <= MODE_DISPLAY;
            active_code <= CODE_RESET;
        end else begin
            mode <= next_mode;
            if (next_mode == MODE_DISPLAY && mode != MODE_DISPLAY) begin
                active_code <= access_code;
            end
        end
    end

    // Shared timer for the cleared indication and the restore dashes.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            show_count <= 32'h00000000;
            o_cleared_show <= 1'b0;
        end else if (do_gclr || do_restore) begin
            show_count <= 32'h00000000;
            o_cleared_show <= do_gclr && !do_restore;
        end else if (show_count != 32'(SHOW_HOLD)) begin
            show_count <= show_count + 32'h00000001;
        end else begin
            o_cleared_show <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupts and outputs
    // ************************************************************
    logic ovf_d;
    wire [ST_W-1:0] events = {mode == MODE_RESTORE && next_mode != mode,
        ovf && !ovf_d, grand_zero, total_reload};
    wire [ST_W-1:0] w1c = (wr && hit_status && i_pstrb[0]) ?
        i_pwdata[ST_W-1:0] : '0;
    wire [ST_W-1:0] next_status = (status & ~w1c) | events;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            status <= '0;
            mask <= '0;
            ovf_d <= 1'b0;
            o_overflow <= 1'b0;
            o_dashes <= 1'b0;
            o_locked <= 1'b0;
        end else begin
            status <= next_status;
            ovf_d <= ovf;
            o_overflow <= ovf;
            o_dashes <= (next_mode == MODE_RESTORE);
            o_locked <= locked;
            if (wr && hit_mask && i_pstrb[0]) begin
                mask <= i_pwdata[ST_W-1:0];
            end
        end
    end

    assign o_irq = |(status & mask);
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    wire [31:0] rd_mux =
        hit_ctrl ? {27'h0, ctrl} :
        hit_reload ? reload_value :
        hit_code ? {16'h0, access_code} :
        hit_status ? {28'h0, status} :
        hit_mask ? {28'h0, mask} :
        hit_total ? 32'(total) :
        hit_glo ? grand_lo :
        hit_ghi ? {grand[63], grand_hi[30:0]} :
        hit_act ? {16'h0, active_code} : 32'h00000000;
    assign o_prdata = rd_sel ? rd_mux : 32'h00000000;

    // ************************************************************
    // Checks
    // ************************************************************
    a_reload_total: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (total_reload && !do_restore) |=> total == $past(reload_ext))
        else $error("total not reloaded");
    a_count_step: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_count && !total_reload && !do_restore)
        |=> total == $past(total) + $past(step))
        else $error("total step wrong");
    a_grand_keep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (total_reload && !i_count && !grand_zero) |=> grand == $past(grand))
        else $error("grand total touched by reset");
    a_grand_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        grand_zero |=> grand == 64'sd0) else $error("grand not zeroed");
    a_restore_dash: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        do_restore |=> o_dashes && total == 64'sd0)
        else $error("restore not shown");
    a_code_apply: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (mode == MODE_CONFIG) |=> active_code == $past(active_code)
        || mode == MODE_DISPLAY) else $error("code applied early");
    a_ovf_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!ctrl[CTRL_LOWER] && total > UPPER_MAX) |=> o_overflow)
        else $error("overflow not flagged");
    a_gesture_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !ctrl[CTRL_TOTAL_EN] [*2] |-> !fire_total)
        else $error("disabled reset fired");
endmodule
